// ---- conv_ctrl.sv ----
/*
 * Conversion control: option and channel enable registers on an Avalon-MM
 * slave, channel sequencer with per-resolution timing, and result store.
 * Assumes synchronous inputs and a sample word valid at the end of each
 * channel's conversion time.
 */
// The Avalon-MM slave port was chosen for this implementation.
// Notes on behaviour
// - selector 0 cycles enabled channels without pause
// - selector 1 does one set, then stops
// - set time is channels times conversion time
// - single set starts only on start bit
// - enable bit cleared by register reset, watchdog
// - single set clears the enable bit itself
// - resolution field picks 24, 12, 6 ms
// - selector resets to single set
// - resolution resets to 14 bit
// - averaging bit picks latest or running average
// - seed bit picks stored or new start value
// - channel enable bits choose set members
`timescale 1ns/10ps
`include "conv_ctrl_consts.svh"
module conv_ctrl #(
    parameter int CONV_CYC_15B = `CONV_MS_15B * (`CLK_HZ / 1000),
    parameter int CONV_CYC_14B = `CONV_MS_14B * (`CLK_HZ / 1000),
    parameter int CONV_CYC_13B = `CONV_MS_13B * (`CLK_HZ / 1000),
    parameter int CNT_W = 18
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // avalon-mm slave
    input wire logic [9:0] address_in,
    input wire logic read_in,
    input wire logic write_in,
    input wire logic [31:0] writedata_in,
    input wire logic [3:0] byteenable_in,
    output logic [31:0] readdata_out,
    output logic waitrequest_out,
    // converter and system events
    input wire logic [15:0] adc_sample_in,
    input wire logic reg_reset_in,
    input wire logic watchdog_expire_in,
    // status
    output logic adc_busy_out,
    output logic [2:0] adc_channel_out,
    output logic [1:0] adc_resolution_out,
    output logic set_done_out
);
    import conv_ctrl_pkg::*;

    if (CNT_W < 2 || CNT_W > 31 || CONV_CYC_13B < 1 || CONV_CYC_14B < 1 || CONV_CYC_15B < 1 ||
        CONV_CYC_15B >= (1 << CNT_W) || CONV_CYC_14B >= (1 << CNT_W) ||
        CONV_CYC_13B >= (1 << CNT_W)) begin : g_bad_param
        $error("conversion counts do not fit the counter");
    end

    sample_if smp ();

    result_average i_result_average (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .smp(smp)
    );

    ////////////////////////////////////////////////////////////////////////
    // bus slave: one wait state, answer at the second edge of a request
    logic ack_r;
    logic ack_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [7:0] idx;
    logic req;
    logic wr_opt;
    logic wr_chen;
    logic [7:0] opt_r;
    logic [7:0] opt_nxt;
    logic [7:0] chen_r;
    logic [7:0] chen_nxt;
    conv_state_t state_r;
    conv_state_t state_nxt;
    logic [2:0] chan_r;
    logic [2:0] chan_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [CNT_W-1:0] conv_cyc;
    logic done_r;
    logic done_nxt;
    logic set_end;
    logic oneshot_clear;
    logic [3:0] first_ch;
    logic [3:0] next_ch;

    assign idx = address_in[9:2];
    assign req = read_in | write_in;
    assign waitrequest_out = req & ~ack_r;
    assign wr_opt = write_in & ack_r & byteenable_in[0] & (idx == `OPT_IDX);
    assign wr_chen = write_in & ack_r & byteenable_in[0] & (idx == `CHEN_IDX);

    always_comb begin
        ack_nxt = req & ~ack_r;
        rdata_nxt = rdata_r;
        if (read_in && !ack_r) begin
            rdata_nxt = 32'h0000_0000; // unmapped reads return zero
            if (idx == `OPT_IDX) begin
                rdata_nxt[7:0] = opt_r & `OPT_WR_MASK;
            end else if (idx == `CHEN_IDX) begin
                rdata_nxt[7:0] = chen_r;
            end else if (idx == `STAT_IDX) begin
                rdata_nxt[4:0] = {chan_r, done_r, state_r == ST_CONV};
            end else if (idx >= `RES_IDX_BASE && idx < `RES_IDX_BASE + 8'h08) begin
                rdata_nxt[15:0] = smp.results[idx[2:0]];
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            ack_r <= ack_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign readdata_out = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_comb begin
        opt_nxt = opt_r;
        chen_nxt = chen_r;
        if (oneshot_clear) begin
            opt_nxt[`OPT_EN_BIT] = 1'b0;
        end
        // a write in the same cycle as the self-clear wins
        if (wr_opt) begin
            opt_nxt = writedata_in[7:0] & `OPT_WR_MASK;
        end
        if (wr_chen) begin
            chen_nxt = writedata_in[7:0] & `CHEN_WR_MASK;
        end
        if (watchdog_expire_in) begin
            opt_nxt[`OPT_EN_BIT] = 1'b0;
        end
        if (reg_reset_in) begin
            opt_nxt = `OPT_RESET;
            chen_nxt = `CHEN_RESET;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            opt_r <= `OPT_RESET;
            chen_r <= `CHEN_RESET;
        end else begin
            opt_r <= opt_nxt;
            chen_r <= chen_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer
    function automatic logic [3:0] find_from(input logic [7:0] en, input logic [3:0] start);
        logic [3:0] hit;
        hit = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (en[i] && 4'(i) >= start) begin
                hit = {1'b1, 3'(i)};
            end
        end
        return hit;
    endfunction

    always_comb begin
        case (opt_r[`OPT_SAMPLE_HI:`OPT_SAMPLE_LO])
            `RES_14B: conv_cyc = CNT_W'(CONV_CYC_14B);
            `RES_13B: conv_cyc = CNT_W'(CONV_CYC_13B);
            // code 11 is left to software to avoid; it times as 15 bit
            default: conv_cyc = CNT_W'(CONV_CYC_15B);
        endcase
    end

    assign first_ch = find_from(chen_r, 4'h0);
    assign next_ch = find_from(chen_r, {1'b0, chan_r} + 4'h1);
    assign set_end = state_r == ST_CONV && cnt_r == conv_cyc - CNT_W'(1) && !next_ch[3];
    assign oneshot_clear = opt_r[`OPT_RATE_BIT] &&
        ((set_end && opt_r[`OPT_EN_BIT]) || (state_r == ST_IDLE && opt_r[`OPT_EN_BIT] && !first_ch[3]));

    always_comb begin
        state_nxt = state_r;
        chan_nxt = chan_r;
        cnt_nxt = cnt_r;
        done_nxt = done_r & ~(read_in & ack_r & (idx == `STAT_IDX));
        smp.valid = 1'b0;
        case (state_r)
            ST_IDLE: begin
                cnt_nxt = '0;
                if (opt_r[`OPT_EN_BIT] && first_ch[3]) begin
                    state_nxt = ST_CONV;
                    chan_nxt = first_ch[2:0];
                end
            end
            ST_CONV: begin
                cnt_nxt = cnt_r + CNT_W'(1);
                if (!opt_r[`OPT_EN_BIT]) begin
                    state_nxt = ST_IDLE;
                end else if (cnt_r == conv_cyc - CNT_W'(1)) begin
                    smp.valid = chen_r[chan_r];
                    cnt_nxt = '0;
                    if (next_ch[3]) begin
                        chan_nxt = next_ch[2:0];
                    end else begin
                        done_nxt = 1'b1;
                        if (opt_r[`OPT_RATE_BIT] || !first_ch[3]) begin
                            state_nxt = ST_IDLE;
                        end else begin
                            chan_nxt = first_ch[2:0];
                        end
                    end
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            state_r <= ST_IDLE;
            chan_r <= 3'h0;
            cnt_r <= '0;
            done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            chan_r <= chan_nxt;
            cnt_r <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    assign smp.chan = chan_r;
    assign smp.data = adc_sample_in;
    assign smp.avg_en = opt_r[`OPT_AVG_BIT];
    assign smp.seed_new = opt_r[`OPT_INIT_BIT];
    assign adc_busy_out = state_r == ST_CONV;
    assign adc_channel_out = chan_r;
    assign adc_resolution_out = opt_r[`OPT_SAMPLE_HI:`OPT_SAMPLE_LO];
    assign set_done_out = set_end;

    ////////////////////////////////////////////////////////////////////////
    // checks
    logic [CNT_W-1:0] span_r;
    logic [CNT_W-1:0] span_nxt;

    always_comb begin
        span_nxt = span_r + CNT_W'(1);
        // restart at every channel end, whether or not its sample was kept
        if (state_r != ST_CONV || cnt_r == conv_cyc - CNT_W'(1)) begin
            span_nxt = CNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            span_r <= CNT_W'(1);
        end else begin
            span_r <= span_nxt;
        end
    end

    // a set end with the enable already gone is an abort, not a finish
    sequence set_finishes;
        set_end && opt_r[`OPT_EN_BIT] && !wr_opt && !watchdog_expire_in && !reg_reset_in;
    endsequence

    sequence set_restarts;
        ##1 state_r == ST_CONV && cnt_r == '0 && {1'b1, chan_r} == $past(first_ch);
    endsequence

    oneshot_stop_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        set_finishes and opt_r[`OPT_RATE_BIT] |=> !opt_r[`OPT_EN_BIT] ##1 state_r == ST_IDLE)
        else $error("single set did not stop and clear its enable");
    cont_cycle_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        set_finishes and !opt_r[`OPT_RATE_BIT] && first_ch[3] |-> set_restarts)
        else $error("continuous mode paused between sets");
    start_needed_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        state_r == ST_IDLE && !opt_r[`OPT_EN_BIT] |=> state_r == ST_IDLE)
        else $error("conversion started without the start bit");
    wdog_clear_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        watchdog_expire_in || reg_reset_in |=> !opt_r[`OPT_EN_BIT])
        else $error("enable bit survived a reset source");
    reset_defaults_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        $past(rst_in) || $past(reg_reset_in) |-> opt_r[`OPT_RATE_BIT] && adc_resolution_out == `RES_14B)
        else $error("option defaults wrong after reset");
    reserved_zero_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        ack_r && read_in && idx == `OPT_IDX |=> readdata_out[1:0] == 2'h0)
        else $error("reserved option bits read nonzero");
    chan_member_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        adc_busy_out && cnt_r == '0 && !$past(wr_chen) && !$past(reg_reset_in) |-> chen_r[adc_channel_out])
        else $error("sequencer picked a disabled channel");
    conv_time_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        smp.valid && $stable(opt_r) |-> span_r == conv_cyc)
        else $error("channel conversion time does not match resolution");
endmodule

// ---- conv_ctrl_consts.svh ----
/*
 * Offsets, field positions, reset values and timing figures of the
 * conversion control block.
 * Assumes inclusion by bare name from the design module and the bench.
 */
`ifndef CONV_CTRL_CONSTS_SVH
`define CONV_CTRL_CONSTS_SVH

// register indices; byte address is four times the index
`define CHEN_IDX 8'h3A
`define OPT_IDX 8'h3B
`define STAT_IDX 8'h40
`define RES_IDX_BASE 8'h50

// option register fields
`define OPT_RATE_BIT 7
`define OPT_EN_BIT 6
`define OPT_SAMPLE_HI 5
`define OPT_SAMPLE_LO 4
`define OPT_AVG_BIT 3
`define OPT_INIT_BIT 2
`define OPT_WR_MASK 8'hFC
`define OPT_RESET 8'h90

// channel enable register, bit 3 has no channel behind it
`define CHEN_WR_MASK 8'hF7
`define CHEN_RESET 8'h00

// resolution codes
`define RES_15B 2'h0
`define RES_14B 2'h1
`define RES_13B 2'h2

// per-channel conversion times in ms, and the clock rate
`define CONV_MS_15B 24
`define CONV_MS_14B 12
`define CONV_MS_13B 6
`define CLK_HZ 10000000

`endif

// ---- conv_ctrl_pkg.sv ----
/*
 * Types shared by the conversion control modules.
 * Assumes the constants header sits in the same folder.
 */
package conv_ctrl_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_CONV = 2'h2
    } conv_state_t;

    typedef logic [7:0][15:0] result_bank_t;
endpackage

// ---- sample_if.sv ----
/*
 * Carries finished conversions from the sequencer to the result store,
 * and the stored results back.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
interface sample_if;
    import conv_ctrl_pkg::*;
    logic valid;
    logic [2:0] chan;
    logic [15:0] data;
    logic avg_en;
    logic seed_new;
    result_bank_t results;

    modport src (output valid, chan, data, avg_en, seed_new, input results);
    modport sink (input valid, chan, data, avg_en, seed_new, output results);
endinterface

// ---- result_average.sv ----
/*
 * Result store: one register per channel, holding either the latest
 * conversion or a running average of successive ones.
 * Assumes valid is a one-cycle pulse from the sequencer.
 */
`timescale 1ns/10ps
module result_average (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // conversions in, results out
    sample_if.sink smp
);
    import conv_ctrl_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    for (genvar i = 0; i < 8; i++) begin : g_chan
        logic [15:0] res_r;
        logic [15:0] res_nxt;
        logic seeded_r;
        logic seeded_nxt;
        logic [16:0] sum;

        always_comb begin
            sum = {1'b0, res_r} + {1'b0, smp.data};
            res_nxt = res_r;
            seeded_nxt = seeded_r & smp.avg_en;
            if (smp.valid && smp.chan == 3'(i)) begin
                if (!smp.avg_en) begin
                    res_nxt = smp.data;
                end else if (!seeded_r && smp.seed_new) begin
                    res_nxt = smp.data;
                end else begin
                    // halving average; seed 0 starts from the stored value
                    res_nxt = sum[16:1];
                end
                seeded_nxt = smp.avg_en;
            end
        end

        always_ff @(posedge ref_clk_in) begin
            if (rst_in) begin
                res_r <= 16'h0000;
                seeded_r <= 1'b0;
            end else begin
                res_r <= res_nxt;
                seeded_r <= seeded_nxt;
            end
        end

        assign smp.results[i] = res_r;

        single_value_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
            smp.valid && smp.chan == 3'(i) && !smp.avg_en |=> res_r == $past(smp.data))
            else $error("single value mode did not store the conversion");
        seed_new_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
            smp.valid && smp.chan == 3'(i) && smp.avg_en && smp.seed_new && !seeded_r
            |=> res_r == $past(smp.data))
            else $error("average did not start from the new conversion");
    end
endmodule

// ---- tb_top.sv ----
/*
 * Self-checking bench for the conversion control block: register access,
 * one-shot and continuous sequencing, resolution timing, averaging, resets.
 * Assumes the design sources and the constants header in the same folder.
 */
`timescale 1ns/10ps
`include "conv_ctrl_consts.svh"
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module tb_top;
    // short conversion times keep the run small
    localparam int C15 = 8;
    localparam int C14 = 4;
    localparam int C13 = 2;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [9:0] address_in = '0;
    logic read_in = 1'b0;
    logic write_in = 1'b0;
    logic [31:0] writedata_in = '0;
    logic [3:0] byteenable_in = '0;
    logic [15:0] adc_sample_in = '0;
    logic reg_reset_in = 1'b0;
    logic watchdog_expire_in = 1'b0;
    logic [31:0] readdata_out;
    logic waitrequest_out;
    logic adc_busy_out;
    logic [2:0] adc_channel_out;
    logic [1:0] adc_resolution_out;
    logic set_done_out;
    int n_errors = 0;
    int total_checks = 0;
    int seed = 32'h2BC43752;
    int run = 0;
    int runs = 0;
    int dones = 0;
    int run_exp;
    logic [31:0] rd_exp;
    logic [31:0] rd_q[$];
    int run_q[$];
    int cyc_tab[3] = '{C15, C14, C13};
    logic [15:0] s_last;
    logic [15:0] s_new;
    logic [16:0] sum;
    int d0;
    int r0;

    conv_ctrl #(.CONV_CYC_15B(C15), .CONV_CYC_14B(C14), .CONV_CYC_13B(C13), .CNT_W(18)) i_conv_ctrl (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .address_in(address_in), .read_in(read_in),
        .write_in(write_in), .writedata_in(writedata_in), .byteenable_in(byteenable_in),
        .readdata_out(readdata_out), .waitrequest_out(waitrequest_out), .adc_sample_in(adc_sample_in),
        .reg_reset_in(reg_reset_in), .watchdog_expire_in(watchdog_expire_in), .adc_busy_out(adc_busy_out),
        .adc_channel_out(adc_channel_out), .adc_resolution_out(adc_resolution_out),
        .set_done_out(set_done_out));

    initial begin
        forever #50 ref_clk_in = ~ref_clk_in;
    end

    ////////////////////////////////////////////////////////////////////////
    // monitor: read data at the answer edge, busy run lengths, set ends
    always @(posedge ref_clk_in) begin
        if (read_in && waitrequest_out === 1'b0) begin
            rd_exp = rd_q.pop_front();
            `CHK(readdata_out, rd_exp);
        end
        if (set_done_out === 1'b1) dones++;
        if (adc_busy_out === 1'b1) begin
            run++;
        end else begin
            if (run != 0 && run_q.size() != 0) begin
                run_exp = run_q.pop_front();
                `CHK(run, run_exp);
            end
            if (run != 0) runs++;
            run = 0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic timeout_hit(input int n);
        n_errors++;
        $display("[FAIL] t=%0t wait expired got=%0h exp=%0h", $time, n, 0);
        tally_and_finish();
    endtask

    // entered just after a rising edge; leaves one edge after release
    task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] d, input logic [3:0] be);
        int n;
        address_in <= {idx, 2'h0};
        writedata_in <= {24'h0, d};
        byteenable_in <= be;
        read_in <= ~wr;
        write_in <= wr;
        n = 0;
        do begin
            @(posedge ref_clk_in);
            n++;
        end while (waitrequest_out !== 1'b0 && n < 100);
        if (n >= 100) timeout_hit(n);
        read_in <= 1'b0;
        write_in <= 1'b0;
        @(posedge ref_clk_in);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(idx, 1'b1, d, 4'hF);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] e);
        rd_q.push_back(e);
        bus(idx, 1'b0, 8'h00, 4'hF);
    endtask

    // one set with a fresh sample word held for the whole set
    task automatic oneshot(input logic [7:0] opt, input int cyc);
        int n;
        int start;
        s_new = 16'($random(seed));
        adc_sample_in <= s_new;
        start = runs;
        run_q.push_back(cyc);
        wr(`OPT_IDX, opt);
        n = 0;
        while (runs == start && n < 3000) begin
            @(posedge ref_clk_in);
            n++;
        end
        if (n >= 3000) timeout_hit(n);
    endtask

    task automatic pulse(input logic wd);
        if (wd) watchdog_expire_in <= 1'b1;
        else reg_reset_in <= 1'b1;
        @(posedge ref_clk_in);
        watchdog_expire_in <= 1'b0;
        reg_reset_in <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        @(posedge ref_clk_in);
        rd(`OPT_IDX, 32'h00000090);
        rd(`CHEN_IDX, 32'h00000000);
        @(negedge ref_clk_in);
        `CHK(adc_resolution_out, 2'h1);
        @(posedge ref_clk_in);
        $display("test reset values done");

        wr(`OPT_IDX, 8'h0F);
        rd(`OPT_IDX, 32'h0000000C);
        bus(`OPT_IDX, 1'b1, 8'hA0, 4'h0);
        rd(`OPT_IDX, 32'h0000000C);
        wr(8'h3C, 8'hFF);
        rd(8'h3C, 32'h00000000);
        wr(`CHEN_IDX, 8'h03);
        wr(`OPT_IDX, 8'h90);
        r0 = runs;
        repeat (20) @(negedge ref_clk_in);
        `CHK(runs, r0);
        `CHK(adc_busy_out, 1'b0);
        @(posedge ref_clk_in);
        $display("test register access done");

        // all three defined resolution codes, two channels per set
        // reserved resolution code 11 is never written
        for (int r = 0; r < 3; r++) begin
            oneshot(8'hC0 | 8'(r << 4), 2 * cyc_tab[r]);
            rd(`OPT_IDX, 32'h80 | 32'(r << 4));
            rd(`RES_IDX_BASE, {16'h0, s_new});
            rd(`RES_IDX_BASE + 8'h01, {16'h0, s_new});
        end
        s_last = s_new;
        wr(`CHEN_IDX, 8'h02);
        oneshot(8'hD0, C14);
        rd(`RES_IDX_BASE, {16'h0, s_last});
        rd(`RES_IDX_BASE + 8'h01, {16'h0, s_new});
        $display("test one-shot sets done");

        wr(`CHEN_IDX, 8'h01);
        oneshot(8'hD8, C14);
        sum = {1'b0, s_last} + {1'b0, s_new};
        rd(`RES_IDX_BASE, {16'h0, sum[16:1]});
        wr(`OPT_IDX, 8'h90);
        oneshot(8'hDC, C14);
        rd(`RES_IDX_BASE, {16'h0, s_new});
        s_last = s_new;
        oneshot(8'hDC, C14);
        sum = {1'b0, s_last} + {1'b0, s_new};
        rd(`RES_IDX_BASE, {16'h0, sum[16:1]});
        $display("test averaging done");

        // any window of three set periods holds exactly three set ends
        wr(`CHEN_IDX, 8'h03);
        wr(`OPT_IDX, 8'h50);
        repeat (10) @(negedge ref_clk_in);
        d0 = dones;
        r0 = runs;
        repeat (6 * C14) @(negedge ref_clk_in);
        `CHK(dones - d0, 3);
        `CHK(runs, r0);
        `CHK(adc_busy_out, 1'b1);
        // set began at a known edge: channel 0 now, channel 1 four cycles on
        `CHK(adc_channel_out, 3'h0);
        repeat (4) @(negedge ref_clk_in);
        `CHK(adc_channel_out, 3'h1);
        @(posedge ref_clk_in);
        pulse(1'b1);
        rd(`OPT_IDX, 32'h00000010);
        wr(`OPT_IDX, 8'h50);
        repeat (5) @(posedge ref_clk_in);
        pulse(1'b0);
        rd(`OPT_IDX, 32'h00000090);
        rd(`CHEN_IDX, 32'h00000000);
        @(negedge ref_clk_in);
        `CHK(adc_busy_out, 1'b0);
        $display("test continuous and resets done");
        tally_and_finish();
    end
endmodule
